// >>> hdl/wdrc_top.sv
// Watchdog and reset control: watchdog, reset sources, flags, registers.
// Assumes the core pulses instruction strobes in the sys_clk domain.
// Overview of operation
// - Watchdog counts only slow oscillator clock
// - Select picks overflow at 2^8 to 2^15
// - Control bit 3 enables the watchdog
// - Upper bits read zero; reset value 0xf
// - Overflow when running: device reset, timeout set
// - Overflow asleep: timeout set, clear PC/SP
// - Clear, halt, pin low, disable clear count
// - Power-on: PC zero, ports all high
// - Pin reset only when option selects it
// - Pin low holds off; delay after release
// - External reset restarts program from zero
// - Low supply must persist minimum time
// - Low voltage reset acts as pin reset
// - Power-up, or clear without overflow, clears powerdown; halt sets it
// - Power-on clears flags; pin/LOW_VOLTAGE_RESET keeps them
// - Overflow asleep leaves both flags set
`timescale 1ns/10ps
module wdrc_top
    import wdrc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst, // Power-on reset
    input wire logic clk_en,
    input wire logic slow_clk, // slow_internal_osc
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic clear_watchdog_instruction,
    input wire logic halt_instruction,
    input wire logic external_reset_pin_n,
    input wire logic ext_reset_option,
    input wire logic low_voltage_reset_option,
    input wire logic low_supply_det,
    output logic device_reset,
    output logic pc_sp_clear,
    output logic ports_preset,
    output logic pin_gpio_in,
    output logic timeout_flag,
    output logic powerdown_flag,
    output logic irq
);
    import wdrc_pkg::*;

    logic [3:0] ctrl_r; // watchdog_control
    logic to_r, pd_r; // Timeout and power-down flags
    logic [WDRC_EV_W-1:0] ists_r, imsk_r; // Sticky events and mask
    logic [WDRC_EV_W-1:0] ev_set;
    logic clear_tgl_r; // Clear request toggle to slow domain
    logic ovf_tgl, ovf_s, ovf_seen_r, ovf_ev;
    logic pin_s, low_s; // Synchronised pins
    logic ext_low, lvr_ev;
    logic [WDRC_DLY_W-1:0] lvr_cnt_r, dly_cnt_r;
    logic hold_r; // Reset held off
    logic por_pend_r; // First cycle after power-on
    logic wd_clear, wr_ctrl, wr_ists, wr_imsk;
    logic [7:0] rd_mux;

    // Pin and oscillator-domain signal synchronisers
    wdrc_sync #(.RST_VAL(1'b1)) u_pin (.clk(sys_clk), .rst(srst),
        .ce(clk_en), .d(external_reset_pin_n), .q(pin_s));
    wdrc_sync u_low (.clk(sys_clk), .rst(srst), .ce(clk_en),
        .d(low_supply_det), .q(low_s));
    wdrc_sync u_ovf (.clk(sys_clk), .rst(srst), .ce(clk_en),
        .d(ovf_tgl), .q(ovf_s));

    // Slow domain counter
    wdrc_slow u_slow (.slow_clk(slow_clk), .slow_rst(srst),
        .clear_tgl(clear_tgl_r), .enable(ctrl_r[WDRC_EN_BIT]),
        .sel(ctrl_r[WDRC_SEL_LSB +: WDRC_SEL_W]), .ovf_tgl(ovf_tgl));

    // Decodes
    assign ext_low = ext_reset_option && !pin_s;
    assign pin_gpio_in = ext_reset_option ? 1'b1 : pin_s;
    assign ovf_ev = (ovf_s != ovf_seen_r);
    assign lvr_ev = low_voltage_reset_option && low_s &&
        (lvr_cnt_r == WDRC_DLY_W'(WDRC_LVR_CYC));
    // Clear sources crossing to the counter
    assign wd_clear = clear_watchdog_instruction || halt_instruction ||
        ext_low || lvr_ev;
    assign wr_ctrl = reg_wr && (reg_addr == WDRC_ADDR_CTRL);
    assign wr_ists = reg_wr && (reg_addr == WDRC_ADDR_ISTS);
    assign wr_imsk = reg_wr && (reg_addr == WDRC_ADDR_IMSK);
    assign ev_set = {lvr_ev, ext_low && !hold_r, ovf_ev};
    assign irq = |(ists_r & imsk_r);
    assign timeout_flag = to_r;
    assign powerdown_flag = pd_r;
    // Read mux; unused bits read zero
    assign rd_mux = (reg_addr == WDRC_ADDR_CTRL) ? {4'h0, ctrl_r} :
        (reg_addr == WDRC_ADDR_STAT) ? {5'h0, hold_r, pd_r, to_r} :
        (reg_addr == WDRC_ADDR_ISTS) ? {5'h0, ists_r} :
        (reg_addr == WDRC_ADDR_IMSK) ? {5'h0, imsk_r} : 8'h00;

    // Registers and read data
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_r <= WDRC_CTRL_RST;
            imsk_r <= '0;
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            if (wr_ctrl)
                ctrl_r <= reg_wdata[3:0];
            else if (ovf_ev && !pd_r)
                ctrl_r <= WDRC_CTRL_RST; // Watchdog overflow reset reloads control; pin and low voltage resets do not
            if (wr_imsk)
                imsk_r <= reg_wdata[WDRC_EV_W-1:0];
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // Sticky events, set wins over write-one-clear
    always_ff @(posedge sys_clk) begin
        if (srst)
            ists_r <= '0;
        else if (clk_en)
            ists_r <= (ists_r & ~(wr_ists ? reg_wdata[WDRC_EV_W-1:0] :
                '0)) | ev_set;
    end

    // Clear toggle and overflow edge tracking
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            clear_tgl_r <= 1'b0;
            ovf_seen_r <= 1'b0;
        end else if (clk_en) begin
            ovf_seen_r <= ovf_s;
            if (wd_clear)
                clear_tgl_r <= ~clear_tgl_r;
        end
    end

    // Status flags
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            to_r <= 1'b0;
            pd_r <= 1'b0;
        end else if (clk_en) begin
            if (ovf_ev)
                to_r <= 1'b1;
            else if (halt_instruction)
                to_r <= 1'b0;
            if (halt_instruction)
                pd_r <= 1'b1;
            else if (clear_watchdog_instruction && !ovf_ev)
                pd_r <= 1'b0;
        end
    end

    // Low supply duration filter
    always_ff @(posedge sys_clk) begin
        if (srst)
            lvr_cnt_r <= '0;
        else if (clk_en) begin
            if (!low_s || !low_voltage_reset_option)
                lvr_cnt_r <= '0; // Short dips ignored
            else if (lvr_cnt_r != WDRC_DLY_W'(WDRC_LVR_CYC))
                lvr_cnt_r <= lvr_cnt_r + WDRC_DLY_W'(1);
        end
    end

    // Reset hold and start-up delay
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            hold_r <= 1'b1;
            dly_cnt_r <= '0;
            por_pend_r <= 1'b1;
        end else if (clk_en) begin
            por_pend_r <= 1'b0;
            if (ext_low || lvr_ev || (ovf_ev && !pd_r)) begin
                hold_r <= 1'b1;
                dly_cnt_r <= '0;
            end else if (hold_r) begin
                if (dly_cnt_r == WDRC_DLY_W'(WDRC_RSTD_CYC - 1))
                    hold_r <= 1'b0;
                else
                    dly_cnt_r <= dly_cnt_r + WDRC_DLY_W'(1);
            end
        end
    end

    // Reset outputs
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            device_reset <= 1'b1;
            pc_sp_clear <= 1'b1;
            ports_preset <= 1'b1;
        end else if (clk_en) begin
            device_reset <= hold_r || ext_low || lvr_ev ||
                (ovf_ev && !pd_r);
            pc_sp_clear <= hold_r || ext_low || lvr_ev ||
                ovf_ev;
            ports_preset <= por_pend_r || hold_r || ext_low ||
                lvr_ev;
        end
    end
endmodule // wdrc_top

// >>> hdl/wdrc_pkg.sv
// Package of constants for the watchdog and reset control block.
// Assumes a 25 MHz system clock and a slow oscillator near 32 kHz.
package wdrc_pkg;
    // Register map
    localparam logic [3:0] WDRC_ADDR_CTRL = 4'h0; // watchdog_control
    localparam logic [3:0] WDRC_ADDR_STAT = 4'h1; // Flags and reset cause
    localparam logic [3:0] WDRC_ADDR_ISTS = 4'h2; // Sticky event status
    localparam logic [3:0] WDRC_ADDR_IMSK = 4'h3; // Event mask
    // Control fields
    localparam int WDRC_EN_BIT = 3; // Enable bit position
    localparam int WDRC_SEL_LSB = 0; // Timeout select low bit
    localparam int WDRC_SEL_W = 3; // Timeout select width
    localparam logic [3:0] WDRC_CTRL_RST = 4'hf; // Enable and select all ones
    // Status fields
    localparam int WDRC_TO_BIT = 0; // Timeout flag
    localparam int WDRC_PD_BIT = 1; // Power-down flag
    // Event bits
    localparam int WDRC_EV_W = 3; // Event count
    localparam int WDRC_EV_WDT = 0; // Watchdog overflow
    localparam int WDRC_EV_EXT = 1; // External pin reset
    localparam int WDRC_EV_LVR = 2; // Low voltage reset
    // Watchdog counter
    localparam int WDRC_CNT_W = 15; // Counter width
    localparam int WDRC_BASE_EXP = 8; // Exponent of code 000
    // Timing
    localparam int WDRC_CLK_HZ = 25000000; // System clock rate
    localparam int WDRC_RSTD_US = 100; // Reset delay time in us
    localparam int WDRC_RSTD_CYC = (WDRC_RSTD_US * (WDRC_CLK_HZ / 1000000));
    localparam int WDRC_LVR_US = 120; // Low supply min duration in us
    localparam int WDRC_LVR_CYC = (WDRC_LVR_US * (WDRC_CLK_HZ / 1000000)) + 1;
    localparam int WDRC_DLY_W = 16; // Delay counter width
endpackage

// >>> hdl/wdrc_sync.sv
// Two-flop level synchroniser.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/10ps
module wdrc_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic d,
    output logic q
);
    logic meta_r; // First stage, read only by second stage

    // Two register stages
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= RST_VAL;
            q <= RST_VAL;
        end else if (ce) begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // wdrc_sync

// >>> hdl/wdrc_slow.sv
// Watchdog counter running on the slow internal oscillator clock.
// Assumes clear_tgl toggles once per clear request from the system domain.
`timescale 1ns/10ps
module wdrc_slow
    import wdrc_pkg::*;
(
    input wire logic slow_clk,
    input wire logic slow_rst,
    input wire logic clear_tgl,
    input wire logic enable,
    input wire logic [2:0] sel,
    output logic ovf_tgl
);
    logic clr_s; // Synchronised clear toggle
    logic clr_seen_r; // Last clear toggle acted on
    logic en_s; // Synchronised enable
    logic [2:0] sel_s; // Synchronised select
    logic [WDRC_CNT_W-1:0] cnt_r; // Watchdog count
    logic [WDRC_CNT_W-1:0] cnt_nxt;
    logic hit; // Selected bit reached
    logic clr_req;

    // All-ones mask of the low 8+sel bits; count wraps at 2^(8+sel)
    function automatic logic [WDRC_CNT_W-1:0] sel_mask(
        input logic [2:0] s
    );
        sel_mask = WDRC_CNT_W'((32'h1 << (WDRC_BASE_EXP + int'(s))) - 1);
    endfunction

    // Bring control across into slow domain
    wdrc_sync u_clr (.clk(slow_clk), .rst(slow_rst), .ce(1'b1),
        .d(clear_tgl), .q(clr_s));
    wdrc_sync #(.RST_VAL(1'b1)) u_en (.clk(slow_clk), .rst(slow_rst),
        .ce(1'b1), .d(enable), .q(en_s));
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sel
            wdrc_sync #(.RST_VAL(1'b1)) u_sel (.clk(slow_clk),
                .rst(slow_rst), .ce(1'b1), .d(sel[g]), .q(sel_s[g]));
        end
    endgenerate

    assign clr_req = (clr_s != clr_seen_r);
    // Overflow at 2^(8+sel) counts
    assign hit = ((cnt_r & sel_mask(sel_s)) == sel_mask(sel_s));
    assign cnt_nxt = cnt_r + WDRC_CNT_W'(1);

    // Count only on the slow clock
    always_ff @(posedge slow_clk) begin
        if (slow_rst) begin
            cnt_r <= '0;
            clr_seen_r <= 1'b0;
            ovf_tgl <= 1'b0;
        end else begin
            clr_seen_r <= clr_s;
            if (clr_req || !en_s) begin
                cnt_r <= '0;
            end else if (hit) begin
                cnt_r <= '0;
                ovf_tgl <= ~ovf_tgl; // One toggle per overflow
            end else begin
                cnt_r <= cnt_nxt;
            end
        end
    end
endmodule // wdrc_slow

// >>> bench/wdrc_checker.sv
// Port checker for the watchdog and reset control block.
// Assumes it is bound to wdrc_top and sees only that module's ports.
`timescale 1ns/10ps
module wdrc_checker (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [3:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic clear_watchdog_instruction,
    input wire logic halt_instruction,
    input wire logic external_reset_pin_n,
    input wire logic ext_reset_option,
    input wire logic low_supply_det,
    input wire logic device_reset,
    input wire logic ports_preset,
    input wire logic pin_gpio_in,
    input wire logic timeout_flag,
    input wire logic powerdown_flag
);
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (srst);
    // Pin low long enough to pass the synchroniser, reset option on
    sequence pin_rst_s;
        (ext_reset_option && !external_reset_pin_n) [*4];
    endsequence
    // Pin low long enough to pass the synchroniser, I/O option
    sequence pin_io_s;
        (!ext_reset_option && !external_reset_pin_n) [*4];
    endsequence
    ctrl_upper_zero_a: assert property (reg_rd && reg_addr == 4'h0
        |=> reg_rdata[7:4] == 4'h0) else $error("ctrl upper bits set");
    halt_flags_a: assert property (clk_en && halt_instruction |=>
        powerdown_flag && !timeout_flag) else $error("halt flags wrong");
    clear_pd_a: assert property (clk_en &&
        clear_watchdog_instruction |=> !powerdown_flag)
        else $error("clear left powerdown");
    por_state_a: assert property (disable iff (1'b0) srst |=>
        !timeout_flag && !powerdown_flag && device_reset && ports_preset)
        else $error("power-on state wrong");
    pin_holds_a: assert property (pin_rst_s |->
        device_reset && ports_preset) else $error("pin reset not held");
    pin_flags_a: assert property (pin_rst_s |=>
        $stable(timeout_flag) && $stable(powerdown_flag))
        else $error("pin reset moved flags");
    pin_io_a: assert property (pin_io_s |-> !pin_gpio_in &&
        $stable(device_reset)) else $error("I/O pin mode wrong");
    pin_forced_a: assert property (ext_reset_option |->
        pin_gpio_in) else $error("I/O input not forced");
    sleep_no_reset_a: assert property (powerdown_flag &&
        external_reset_pin_n && !low_supply_det |=> !$rose(device_reset))
        else $error("reset while asleep");
endmodule // wdrc_checker

bind wdrc_top wdrc_checker u_chk (.sys_clk, .srst, .clk_en, .reg_addr,
    .reg_rd, .reg_rdata, .clear_watchdog_instruction, .halt_instruction,
    .external_reset_pin_n, .ext_reset_option, .low_supply_det, .device_reset,
    .ports_preset, .pin_gpio_in, .timeout_flag, .powerdown_flag);

// >>> bench/tb_top.sv
// Testbench for the watchdog and reset control block.
// Assumes a fast slow clock stand-in so overflows fit in the run.
`timescale 1ns/10ps
module tb_top;
    logic sys_clk = 1'h0, srst = 1'h1, slow_clk = 1'h0; // Clocks, reset
    logic [3:0] reg_addr = 4'h0; // Bus address
    logic [7:0] reg_wdata = 8'h00, reg_rdata; // Bus data
    logic reg_wr = 1'h0, reg_rd = 1'h0; // Bus strobes
    logic clear_watchdog_instruction = 1'h0, halt_instruction = 1'h0;
    logic external_reset_pin_n = 1'h1, ext_reset_option = 1'h0;
    logic low_voltage_reset_option = 1'h0, low_supply_det = 1'h0;
    logic device_reset, pc_sp_clear, ports_preset, pin_gpio_in;
    logic timeout_flag, powerdown_flag, irq, sp; // sp: PC/SP clear seen
    int failures = 0, checks_done = 0, n; // n: cycles waited
    wdrc_top dut (.sys_clk, .srst, .clk_en(1'h1), .slow_clk, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .clear_watchdog_instruction,
        .halt_instruction, .external_reset_pin_n, .ext_reset_option,
        .low_voltage_reset_option, .low_supply_det, .device_reset,
        .pc_sp_clear, .ports_preset, .pin_gpio_in, .timeout_flag,
        .powerdown_flag, .irq);
    // 25 MHz system clock; slow clock ten times slower, edges apart
    always #20 sys_clk = ~sys_clk;
    always #200 slow_clk = ~slow_clk;
    // Compare one result and count it
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Bus write of one byte
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
    endtask
    // Bus read, data judged in the cycle after the strobe
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        #1 chk(reg_rdata, e);
    endtask
    // One-cycle halt (h high) or clear instruction
    task ins(input logic h);
        @(posedge sys_clk);
        halt_instruction <= h;
        clear_watchdog_instruction <= !h;
        @(posedge sys_clk);
        halt_instruction <= 1'h0;
        clear_watchdog_instruction <= 1'h0;
    endtask
    // Wait for device_reset to reach v, at most lim cycles
    task wt(input logic v, input int lim);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1 n++;
            if (pc_sp_clear === 1'h1) sp = 1'h1;
        end while (device_reset !== v && n < lim);
    endtask
    // Verdict and end of run
    task end_sim;
        if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Power-on state, hold time and control register
    task s_reset;
        #1 chk({6'h0, timeout_flag, powerdown_flag}, 8'h00);
        chk({6'h0, device_reset, ports_preset}, 8'h03);
        wt(1'h0, 2600);
        chk({7'h0, n > 2495 && n < 2506}, 8'h01);
        rd(4'h0, 8'h0f);
        wr(4'h0, 8'hf5);
        rd(4'h0, 8'h05);
        rd(4'h7, 8'h00);
    endtask
    // Overflow while running with select code 1
    task s_norm;
        wr(4'h0, 8'h09);
        ins(1'h0);
        wt(1'h1, 5000);
        chk({7'h0, device_reset}, 8'h00);
        wt(1'h1, 400);
        chk({6'h0, device_reset, timeout_flag}, 8'h03);
        wt(1'h0, 2600);
        rd(4'h0, 8'h0f);
        rd(4'h1, 8'h01);
    endtask
    // Timely clears keep it alive; disabling stops it
    task s_clear;
        wr(4'h0, 8'h08);
        repeat (3) begin
            ins(1'h0);
            wt(1'h1, 2000);
            chk({7'h0, device_reset}, 8'h00);
        end
        wr(4'h0, 8'h00);
        wt(1'h1, 4000);
        chk({7'h0, device_reset}, 8'h00);
    endtask
    // Overflow while halted, event bit and interrupt
    task s_sleep;
        wr(4'h3, 8'h00);
        wr(4'h2, 8'h07);
        wr(4'h0, 8'h08);
        ins(1'h1);
        #1 chk({6'h0, timeout_flag, powerdown_flag}, 8'h01);
        sp = 1'h0;
        wt(1'h1, 2800);
        chk({6'h0, device_reset, sp}, 8'h01);
        rd(4'h1, 8'h03);
        rd(4'h2, 8'h01);
        wr(4'h3, 8'h01);
        #1 chk({7'h0, irq}, 8'h01);
        wr(4'h2, 8'h01);
        #1 chk({7'h0, irq}, 8'h00);
        wr(4'h0, 8'h00);
    endtask
    // Reset pin as plain input, then as reset source
    task s_pin;
        @(posedge sys_clk);
        external_reset_pin_n <= 1'h0;
        repeat (10) @(posedge sys_clk);
        #1 chk({6'h0, pin_gpio_in, device_reset}, 8'h00);
        @(posedge sys_clk);
        ext_reset_option <= 1'h1;
        repeat (10) @(posedge sys_clk);
        #1 chk({4'h0, pin_gpio_in, device_reset, ports_preset,
            pc_sp_clear}, 8'h0f);
        @(posedge sys_clk);
        external_reset_pin_n <= 1'h1;
        wt(1'h0, 2600);
        chk({7'h0, n > 2498 && n < 2510}, 8'h01);
        rd(4'h1, 8'h03);
    endtask
    // Short supply dip ignored, long dip resets
    task s_lvr;
        @(posedge sys_clk);
        ext_reset_option <= 1'h0;
        low_voltage_reset_option <= 1'h1;
        low_supply_det <= 1'h1;
        wt(1'h1, 2900);
        low_supply_det <= 1'h0;
        chk({7'h0, device_reset}, 8'h00);
        repeat (10) @(posedge sys_clk);
        low_supply_det <= 1'h1;
        wt(1'h1, 3100);
        chk({7'h0, n > 3000 && n < 3010}, 8'h01);
        chk({6'h0, device_reset, ports_preset}, 8'h03);
        low_supply_det <= 1'h0;
        wt(1'h0, 2600);
        rd(4'h1, 8'h03);
    endtask
    // Two-cycle reset, then the scenarios in turn
    initial begin
        repeat (2) @(posedge sys_clk);
        srst <= 1'h0;
        s_reset;
        s_norm;
        s_clear;
        s_sleep;
        s_pin;
        s_lvr;
        end_sim;
    end
    // Cuts a hung run short
    initial begin
        #3000000;
        failures++;
        end_sim;
    end
endmodule // tb_top
